// >>> hdl/fmr_alarm_eval.sv
// Alarm condition evaluator: compares readings with limits each cycle.
// Assumes readings are already registered by the parent bank.
`timescale 1ns/1ps
module fmr_alarm_eval
	import fmr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input fmr_pkg::fmr_temp_t remoteTemp,
	input fmr_pkg::fmr_temp_t localTemp,
	input fmr_pkg::fmr_limits_t limits,
	input wire logic [15:0] fan1Count,
	input wire logic [15:0] fan2Count,
	input wire logic [15:0] countThreshold,
	input fmr_pkg::fmr_fan_t fan1In,
	input fmr_pkg::fmr_fan_t fan2In,
	input wire logic diodeFault,
	output fmr_pkg::fmr_cond_t cond
);
	// ***************************************************************
	// Conditions
	// ***************************************************************
	fmr_cond_t cond_nxt;
	wire fan1Bad = (fan1Count > countThreshold) | fan1In.stopped | fan1In.overflow;
	wire fan2Bad = (fan2Count > countThreshold) | fan2In.stopped | fan2In.overflow;

	assign cond_nxt.diode = diodeFault;
	assign cond_nxt.localHigh = fmr_above(localTemp, limits.localHigh);
	assign cond_nxt.localOver = fmr_above(localTemp, limits.localOver);
	assign cond_nxt.remoteHigh = fmr_above(remoteTemp, limits.remoteHigh);
	assign cond_nxt.remoteOver = fmr_above(remoteTemp, limits.remoteOver);
	assign cond_nxt.fan2 = fan2Bad;
	assign cond_nxt.fan1 = fan1Bad;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			cond <= '0;
		else
			cond <= cond_nxt;
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	chk_diode_cond: assert property (@(posedge sys_clk) disable iff (rst)
		diodeFault |=> cond.diode)
		else $error("diode fault not seen");
	chk_local_high: assert property (@(posedge sys_clk) disable iff (rst)
		cond.localHigh == $past($signed(localTemp) > $signed(limits.localHigh)))
		else $error("local high compare wrong");
	chk_local_over: assert property (@(posedge sys_clk) disable iff (rst)
		(localTemp == limits.localOver) |=> !cond.localOver)
		else $error("local over set at set point");
	chk_remote_cmp: assert property (@(posedge sys_clk) disable iff (rst)
		cond.remoteOver == $past($signed(remoteTemp) > $signed(limits.remoteOver)))
		else $error("remote over compare wrong");
	chk_fan_fail: assert property (@(posedge sys_clk) disable iff (rst)
		(fan1In.stopped || fan1In.overflow || fan1Count > countThreshold) |=> cond.fan1)
		else $error("fan1 failure missed");
endmodule

// >>> hdl/fmr_readout_bank.sv
// Read-only fan count, temperature and alarm status bank on AXI4-Lite.
// Assumes fan counts and temperatures arrive as strobed words on sys_clk.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps

module fmr_readout_bank
	import fmr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [fmr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [fmr_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [fmr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [fmr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input fmr_pkg::fmr_fan_t fan1In,
	input fmr_pkg::fmr_fan_t fan2In,
	input wire logic [15:0] countThreshold,
	input fmr_pkg::fmr_temp_t remoteTemp,
	input wire logic remoteValid,
	input fmr_pkg::fmr_temp_t localTemp,
	input wire logic localValid,
	input fmr_pkg::fmr_limits_t limits,
	input wire logic diodeFault,
	input wire logic nvWriteError,
	input wire logic nvWriteGood,
	input wire logic softPor,
	input wire logic bootCorrupt,
	output logic alert
);
	// ***************************************************************
	// Measurement holding registers
	// ***************************************************************
	logic [15:0] fan1Count_r;
	logic [15:0] fan2Count_r;
	fmr_temp_t remoteTemp_r;
	fmr_temp_t localTemp_r;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			fan1Count_r <= RESET_COUNT;
			fan2Count_r <= RESET_COUNT;
			remoteTemp_r <= RESET_TEMP;
			localTemp_r <= RESET_TEMP;
		end
		else
		begin
			if (fan1In.valid)
				fan1Count_r <= fan1In.count;
			if (fan2In.valid)
				fan2Count_r <= fan2In.count;
			if (remoteValid)
				remoteTemp_r <= remoteTemp;
			if (localValid)
				localTemp_r <= localTemp;
		end
	end

	// ***************************************************************
	// Alarm conditions
	// ***************************************************************
	fmr_cond_t cond;

	fmr_alarm_eval u_eval
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.remoteTemp(remoteTemp_r),
		.localTemp(localTemp_r),
		.limits(limits),
		.fan1Count(fan1Count_r),
		.fan2Count(fan2Count_r),
		.countThreshold(countThreshold),
		.fan1In(fan1In),
		.fan2In(fan2In),
		.diodeFault(diodeFault),
		.cond(cond)
	);

	// ***************************************************************
	// Read address decode
	// ***************************************************************
	wire [7:0] rdIndex = s_axi_araddr[9:2];
	wire rdAligned = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[11:10] == 2'h0);
	wire rdTaken = s_axi_arvalid && s_axi_arready;
	wire rdStatus = rdTaken && rdAligned && (rdIndex == IDX_STATUS);
	logic [7:0] status_r;
	logic [7:0] rdByte;
	logic rdHit;

	always_comb
	begin
		rdHit = rdAligned;
		case (rdIndex)
			IDX_FAN1_HIGH: rdByte = fan1Count_r[15:8];
			IDX_FAN1_LOW: rdByte = fan1Count_r[7:0];
			IDX_FAN2_HIGH: rdByte = fan2Count_r[15:8];
			IDX_FAN2_LOW: rdByte = fan2Count_r[7:0];
			IDX_REMOTE_HIGH: rdByte = {remoteTemp_r.sign, remoteTemp_r.whole};
			IDX_REMOTE_LOW: rdByte = {remoteTemp_r.frac, FRAC_PAD};
			IDX_LOCAL_HIGH: rdByte = {localTemp_r.sign, localTemp_r.whole};
			IDX_LOCAL_LOW: rdByte = {localTemp_r.frac, FRAC_PAD};
			IDX_STATUS: rdByte = status_r;
			default:
			begin
				rdByte = RESET_BYTE;
				rdHit = 1'b0;
			end
		endcase
	end

	// ***************************************************************
	// Status register
	// ***************************************************************
	logic [7:0] status_nxt;
	logic goodWrite_r;
	logic bootSeen_r;
	logic progCorrupt_nxt;
	wire [6:0] alarmSet = cond;
	// Clear applies to alarms only; the set term is ORed after it so a
	// fault in the read cycle is never lost
	wire [6:0] alarmKeep = rdStatus ? 7'h00 : status_r[6:0];
	wire progClear = softPor && goodWrite_r;

	always_comb
	begin
		progCorrupt_nxt = status_r[BIT_PROG];
		if (progClear)
			progCorrupt_nxt = 1'b0;
		if (nvWriteError || (!bootSeen_r && bootCorrupt))
			progCorrupt_nxt = 1'b1;
		status_nxt = {progCorrupt_nxt, alarmKeep | alarmSet};
	end

	// Corruption that survived power-off is reported by the nonvolatile
	// side on bootCorrupt and taken once after reset release
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			status_r <= RESET_BYTE;
			goodWrite_r <= 1'b0;
			bootSeen_r <= 1'b0;
		end
		else
		begin
			status_r <= status_nxt;
			bootSeen_r <= 1'b1;
			if (nvWriteError || progClear)
				goodWrite_r <= 1'b0;
			else if (nvWriteGood)
				goodWrite_r <= 1'b1;
		end
	end

	// Diode fault is left out of the alert term
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			alert <= 1'b0;
		else
			alert <= |(status_nxt & ALERT_MASK);
	end

	// ***************************************************************
	// AXI4-Lite read channel
	// ***************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (rdTaken)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {UPPER_ZERO, rdHit ? rdByte : RESET_BYTE};
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	// ***************************************************************
	// AXI4-Lite write channel
	// ***************************************************************
	// Every register is read-only, so writes are taken and refused
	logic awHeld_r;
	logic wHeld_r;
	wire awTaken = s_axi_awvalid && s_axi_awready;
	wire wTaken = s_axi_wvalid && s_axi_wready;
	wire awHave = awHeld_r || awTaken;
	wire wHave = wHeld_r || wTaken;
	wire bDone = s_axi_bvalid && s_axi_bready;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (awHave && wHave && !s_axi_bvalid)
		begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= RESP_SLVERR;
		end
		else
		begin
			awHeld_r <= awHave;
			wHeld_r <= wHave;
			s_axi_awready <= !awHave && !s_axi_bvalid;
			s_axi_wready <= !wHave && !s_axi_bvalid;
			if (bDone)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	wire lowReadF1 = rdTaken && rdAligned && rdIndex == IDX_FAN1_LOW;
	wire highReadF1 = rdTaken && rdAligned && rdIndex == IDX_FAN1_HIGH;
	wire rdFan2 = rdTaken && rdAligned && (rdIndex == IDX_FAN2_HIGH);
	wire rdRemLow = rdTaken && rdAligned && (rdIndex == IDX_REMOTE_LOW);
	wire rdFan2Low = rdTaken && rdAligned && (rdIndex == IDX_FAN2_LOW);
	wire rdRemHigh = rdTaken && rdAligned && (rdIndex == IDX_REMOTE_HIGH);
	wire rdLocHigh = rdTaken && rdAligned && (rdIndex == IDX_LOCAL_HIGH);
	wire rdLocLow = rdTaken && rdAligned && (rdIndex == IDX_LOCAL_LOW);

	chk_fan1_low: assert property (@(posedge sys_clk) disable iff (rst)
		lowReadF1 |=> s_axi_rvalid && s_axi_rdata == {UPPER_ZERO, $past(fan1Count_r[7:0])})
		else $error("fan1 low byte wrong");
	chk_fan1_high: assert property (@(posedge sys_clk) disable iff (rst)
		highReadF1 |=> s_axi_rdata[7:0] == $past(fan1Count_r[15:8]))
		else $error("fan1 high byte wrong");
	chk_fan2_high: assert property (@(posedge sys_clk) disable iff (rst)
		rdFan2 |=> s_axi_rdata[7:0] == $past(fan2Count_r[15:8]))
		else $error("fan2 high byte wrong");
	chk_fan_count: assert property (@(posedge sys_clk) disable iff (rst)
		fan2In.valid |=> fan2Count_r == $past(fan2In.count))
		else $error("fan2 count not captured");
	chk_temp_frac: assert property (@(posedge sys_clk) disable iff (rst)
		rdRemLow |=> s_axi_rdata[4:0] == FRAC_PAD)
		else $error("temperature pad bits not zero");
	chk_status_clear: assert property (@(posedge sys_clk) disable iff (rst)
		rdStatus && cond == '0 |=> status_r[6:0] == 7'h00)
		else $error("status read did not clear");
	chk_alarm_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		status_r[0] && !rdStatus |=> status_r[0])
		else $error("alarm dropped without read");
	chk_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
		rdStatus && cond.fan1 |=> status_r[0])
		else $error("alarm lost in read cycle");
	chk_prog_error: assert property (@(posedge sys_clk) disable iff (rst)
		nvWriteError |=> status_r[BIT_PROG])
		else $error("program error not flagged");
	chk_prog_keep: assert property (@(posedge sys_clk) disable iff (rst)
		status_r[BIT_PROG] && !softPor |=> status_r[BIT_PROG])
		else $error("program flag cleared early");
	chk_diode_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		(status_r & ALERT_MASK) == 8'h00 |-> !alert)
		else $error("alert without alert-class alarm");
	chk_read_answer: assert property (@(posedge sys_clk) disable iff (rst)
		rdTaken |=> s_axi_rvalid)
		else $error("read not answered");
	chk_fan2_low: assert property (@(posedge sys_clk) disable iff (rst)
		rdFan2Low |=> s_axi_rdata[7:0] == $past(fan2Count_r[7:0]))
		else $error("fan2 low byte wrong");
	chk_remote_byte: assert property (@(posedge sys_clk) disable iff (rst)
		rdRemHigh |=> s_axi_rdata[7:0] == $past(remoteTemp_r[10:3]))
		else $error("remote high byte wrong");
	chk_local_byte: assert property (@(posedge sys_clk) disable iff (rst)
		rdLocHigh |=> s_axi_rdata[7:0] == $past(localTemp_r[10:3]))
		else $error("local high byte wrong");
	chk_local_frac: assert property (@(posedge sys_clk) disable iff (rst)
		rdLocLow |=> s_axi_rdata[7:0] == {$past(localTemp_r[2:0]), FRAC_PAD})
		else $error("local low byte wrong");
	chk_read_refused: assert property (@(posedge sys_clk) disable iff (rst)
		rdTaken && !rdHit |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
		else $error("bad read address accepted");
	chk_boot_flag: assert property (@(posedge sys_clk) disable iff (rst)
		!bootSeen_r && bootCorrupt |=> status_r[BIT_PROG])
		else $error("boot corruption not flagged");
	chk_prog_clear: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(status_r[BIT_PROG]) |-> $past(softPor && goodWrite_r))
		else $error("program flag cleared without good write");

	cov_status_read: cover property (@(posedge sys_clk) disable iff (rst)
		rdStatus && status_r[BIT_DIODE]);
	cov_alert_rise: cover property (@(posedge sys_clk) disable iff (rst) $rose(alert));
	cov_write_refused: cover property (@(posedge sys_clk) disable iff (rst)
		s_axi_bvalid && s_axi_bready);
	cov_prog_clear: cover property (@(posedge sys_clk) disable iff (rst)
		$fell(status_r[BIT_PROG]));
	cov_fault_again: cover property (@(posedge sys_clk) disable iff (rst)
		rdStatus && cond.fan1);
endmodule

// >>> shared/fmr_pkg.sv
// Constants, types and helpers of the fan and temperature readout bank.
// Assumes a 32-bit AXI4-Lite register port and one synchronous clock.
package fmr_pkg;

	// ***************************************************************
	// Bus and address map
	// ***************************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Register index; byte address is four times the index
	localparam logic [7:0] IDX_FAN1_HIGH = 8'h52;
	localparam logic [7:0] IDX_FAN1_LOW = 8'h53;
	localparam logic [7:0] IDX_FAN2_HIGH = 8'h54;
	localparam logic [7:0] IDX_FAN2_LOW = 8'h55;
	localparam logic [7:0] IDX_REMOTE_HIGH = 8'h56;
	localparam logic [7:0] IDX_REMOTE_LOW = 8'h57;
	localparam logic [7:0] IDX_LOCAL_HIGH = 8'h58;
	localparam logic [7:0] IDX_LOCAL_LOW = 8'h59;
	localparam logic [7:0] IDX_STATUS = 8'h5a;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ***************************************************************
	// Reset values and field layout
	// ***************************************************************
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_COUNT = 16'h0000;
	localparam logic [10:0] RESET_TEMP = 11'h000;
	localparam int BIT_PROG = 7;
	localparam int BIT_DIODE = 6;
	localparam logic [7:0] ALARM_MASK = 8'h7f;
	localparam logic [7:0] ALERT_MASK = 8'h3f;
	localparam logic [4:0] FRAC_PAD = 5'h00;
	localparam logic [23:0] UPPER_ZERO = 24'h000000;

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef struct packed
	{
		logic sign;
		logic [6:0] whole;
		logic [2:0] frac;
	} fmr_temp_t;

	typedef struct packed
	{
		fmr_temp_t localHigh;
		fmr_temp_t localOver;
		fmr_temp_t remoteHigh;
		fmr_temp_t remoteOver;
	} fmr_limits_t;

	typedef struct packed
	{
		logic [15:0] count;
		logic valid;
		logic stopped;
		logic overflow;
	} fmr_fan_t;

	// Same order as status bits 6..0
	typedef struct packed
	{
		logic diode;
		logic localHigh;
		logic localOver;
		logic remoteHigh;
		logic remoteOver;
		logic fan2;
		logic fan1;
	} fmr_cond_t;

	// Signed fixed-point compare, strictly above the limit
	function automatic logic fmr_above(fmr_temp_t t, fmr_temp_t lim);
		return $signed(t) > $signed(lim);
	endfunction

endpackage

// >>> verification/fan_temp_monitor_readout_test.sv
// Self-checking bench for the readout bank over AXI4-Lite.
// Assumes the front end model and the bank run on one 200 MHz clock.
`timescale 1ns/1ps
module fan_temp_monitor_readout_test;
	import fmr_pkg::*;

	// ***************************************************************
	// Signals
	// ***************************************************************
	logic sys_clk;
	logic rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, alert;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	fmr_fan_t fan1In, fan2In;
	fmr_temp_t remoteTemp, localTemp;
	logic remoteValid, localValid;
	logic [15:0] countThreshold = 16'hfedc;
	fmr_limits_t limits = {11'h190, 11'h1e0, 11'h190, 11'h1e0};
	logic diodeFault = 1'b0, nvWriteError = 1'b0, nvWriteGood = 1'b0;
	logic softPor = 1'b0, bootCorrupt = 1'b0, reqValid = 1'b0;
	logic [2:0] reqSel = 3'h0;
	logic [15:0] reqWord = 16'h0000;
	int errCount = 0, checked = 0;
	logic [7:0] expB [0:8] = '{8'h12, 8'h34, 8'hfe, 8'hdc, 8'he6, 8'he0, 8'h1e, 8'h80, 8'h00};

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	fmr_front_model i_fmr_front_model (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid),
		.reqSel(reqSel), .reqWord(reqWord), .fan1In(fan1In), .fan2In(fan2In),
		.remoteTemp(remoteTemp), .remoteValid(remoteValid), .localTemp(localTemp),
		.localValid(localValid));

	// Write data content is ignored by the bank, so it stays fixed
	fmr_readout_bank i_fmr_readout_bank (.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(32'h00000000), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fan1In(fan1In),
		.fan2In(fan2In), .countThreshold(countThreshold), .remoteTemp(remoteTemp),
		.remoteValid(remoteValid), .localTemp(localTemp), .localValid(localValid),
		.limits(limits), .diodeFault(diodeFault), .nvWriteError(nvWriteError),
		.nvWriteGood(nvWriteGood), .softPor(softPor), .bootCorrupt(bootCorrupt),
		.alert(alert));

	// ***************************************************************
	// Tasks
	// ***************************************************************
	task automatic summarize;
		if (errCount == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			errCount++;
		end
	endtask

	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction

	// Samples at the edge, before the bank's flops update
	task automatic rd(input logic [11:0] a, input logic [31:0] expData, input logic [1:0] expResp);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (s_axi_arready !== 1'b1 && n < 100);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		if (n >= 100)
		begin
			errCount++;
			summarize();
		end
		else
		begin
			chk(s_axi_rdata, expData);
			chk({30'h0, s_axi_rresp}, {30'h0, expResp});
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [1:0] expResp);
		int n;
		logic aDone, wDone;
		n = 0;
		aDone = 1'b0;
		wDone = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (!aDone && s_axi_awready === 1'b1)
			begin
				aDone = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wDone && s_axi_wready === 1'b1)
			begin
				wDone = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!(aDone && wDone) && n < 100);
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		if (n >= 100)
		begin
			errCount++;
			summarize();
		end
		else
			chk({30'h0, s_axi_bresp}, {30'h0, expResp});
	endtask

	task automatic send(input logic [2:0] sel, input logic [15:0] word);
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqSel <= sel;
		reqWord <= word;
		@(posedge sys_clk);
		reqValid <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic pulse(input int which);
		@(posedge sys_clk);
		case (which)
			0: nvWriteError <= 1'b1;
			1: nvWriteGood <= 1'b1;
			default: softPor <= 1'b1;
		endcase
		@(posedge sys_clk);
		{nvWriteError, nvWriteGood, softPor} <= 3'h0;
		repeat (3) @(posedge sys_clk);
	endtask

	// Each status bit 6..0 gets its own cause; limits drop below the readings when on and go back to their defaults when off
	task automatic apply(input int b, input logic on);
		@(posedge sys_clk);
		case (b)
			0: send(3'h4, {15'h0000, on});
			1: countThreshold <= on ? 16'hfedb : 16'hfedc;
			2: limits.remoteOver <= on ? 11'h700 : 11'h1e0;
			3: limits.remoteHigh <= on ? 11'h700 : 11'h190;
			4: limits.localOver <= on ? 11'h000 : 11'h1e0;
			5: limits.localHigh <= on ? 11'h000 : 11'h190;
			default: diodeFault <= on;
		endcase
		repeat (5) @(posedge sys_clk);
	endtask

	task automatic doReset;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial
	begin
		logic [31:0] m;
		doReset();
		send(3'h0, 16'h1234);
		send(3'h1, 16'hfedc);
		send(3'h2, 16'h0737);
		send(3'h3, 16'h00f4);
		for (int i = 0; i < 9; i++)
			rd(ba(8'(IDX_FAN1_HIGH + i)), {24'h0, expB[i]}, RESP_OKAY);
		for (int b = 0; b < 7; b++)
		begin
			m = 32'h1 << b;
			apply(b, 1'b1);
			chk({31'h0, alert}, {31'h0, b != 6});
			rd(ba(IDX_STATUS), m, RESP_OKAY);
			apply(b, 1'b0);
			rd(ba(IDX_STATUS), m, RESP_OKAY);
			rd(ba(IDX_STATUS), 32'h0, RESP_OKAY);
			chk({31'h0, alert}, 32'h0);
			apply(b, 1'b1);
			rd(ba(IDX_STATUS), m, RESP_OKAY);
			apply(b, 1'b0);
			rd(ba(IDX_STATUS), m, RESP_OKAY);
		end
		// Readings equal to their limits must not alarm
		limits <= {11'h0f4, 11'h0f4, 11'h737, 11'h737};
		repeat (5) @(posedge sys_clk);
		rd(ba(IDX_STATUS), 32'h0, RESP_OKAY);
		limits <= {11'h190, 11'h1e0, 11'h190, 11'h1e0};
		// Unmapped, misaligned and write accesses are refused
		rd(12'h16c, 32'h0, RESP_SLVERR);
		rd(12'h144, 32'h0, RESP_SLVERR);
		rd(12'h169, 32'h0, RESP_SLVERR);
		wr(ba(IDX_STATUS), RESP_SLVERR);
		rd(ba(IDX_STATUS), 32'h0, RESP_OKAY);
		pulse(0);
		rd(ba(IDX_STATUS), 32'h80, RESP_OKAY);
		rd(ba(IDX_STATUS), 32'h80, RESP_OKAY);
		pulse(2);
		rd(ba(IDX_STATUS), 32'h80, RESP_OKAY);
		chk({31'h0, alert}, 32'h0);
		pulse(1);
		pulse(2);
		rd(ba(IDX_STATUS), 32'h0, RESP_OKAY);
		bootCorrupt <= 1'b1;
		doReset();
		// Level must still stand at the first edge after release
		rd(ba(IDX_STATUS), 32'h80, RESP_OKAY);
		bootCorrupt <= 1'b0;
		for (int i = 0; i < 8; i++)
			rd(ba(8'(IDX_FAN1_HIGH + i)), 32'h0, RESP_OKAY);
		pulse(1);
		pulse(2);
		rd(ba(IDX_STATUS), 32'h0, RESP_OKAY);
		summarize();
	end
endmodule

// >>> verification/fmr_front_model.sv
// Fan tachometer and temperature front end feeding the readout bank.
// Assumes the bench posts one request per cycle on sys_clk.
`timescale 1ns/1ps
module fmr_front_model
	import fmr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reqValid,
	input wire logic [2:0] reqSel,
	input wire logic [15:0] reqWord,
	output fmr_pkg::fmr_fan_t fan1In,
	output fmr_pkg::fmr_fan_t fan2In,
	output fmr_pkg::fmr_temp_t remoteTemp,
	output logic remoteValid,
	output fmr_pkg::fmr_temp_t localTemp,
	output logic localValid
);
	import fmr_pkg::*;

	// ***************************************************************
	// Held word, strobes and fan flags
	// ***************************************************************
	logic [15:0] word_r;
	logic [3:0] strobe_r;
	logic [3:0] flags_r;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			word_r <= 16'h0000;
			strobe_r <= 4'h0;
			flags_r <= 4'h0;
		end
		else
		begin
			strobe_r <= 4'h0;
			if (reqValid && reqSel == 3'h4)
				flags_r <= reqWord[3:0];
			if (reqValid && reqSel != 3'h4)
			begin
				word_r <= reqWord;
				strobe_r[reqSel[1:0]] <= 1'b1;
			end
		end
	end

	// Data only valid under its strobe; inverted otherwise to expose stale use
	assign fan1In = {strobe_r[0] ? word_r : ~word_r, strobe_r[0], flags_r[0], flags_r[1]};
	assign fan2In = {strobe_r[1] ? word_r : ~word_r, strobe_r[1], flags_r[2], flags_r[3]};
	assign remoteTemp = strobe_r[2] ? word_r[10:0] : ~word_r[10:0];
	assign remoteValid = strobe_r[2];
	assign localTemp = strobe_r[3] ? word_r[10:0] : ~word_r[10:0];
	assign localValid = strobe_r[3];
endmodule
